// *** core/srm_register_map.sv ***
// register map and command decode behind the 16-bit serial control port
// ****************************************
// Overview of operation
// - addresses 1 to 30 are read/write control
// - bit seven picks read or read-and-write
// - written value shows only in later frames
// - addresses 65 to 126 are status registers
// - bit seven set clears clearable status bits
// - wake level tracks pin, never cleared
// - mode bits follow the mode entered
// - sleep turns on transceivers into wake capable
// - triggered failure outputs stay on in sleep
// - supply two config accepted only in normal
// - supply two diagnosis runs in low power
// - transceivers follow setting after mode change
// - address bits 6:0, flag 7, data 15:8
// - flag zero reads, one writes, whole bytes
// - summary byte flags non-empty status registers
// - no command taken in restart, sleep, fail-safe
// ****************************************
`include "srm_map.svh"

module srm_register_map
   import srm_pkg::*;
(
   input  wire logic           clk_sys,
   input  wire logic           rst_b,
   input  wire logic           csPin_b,
   input  wire logic           sclkPin,
   input  wire logic           sdiPin,
   input  wire logic           wakePin,
   input  wire srm_mode_t      actualMode,
   input  wire srm_stat_bank_t statusEvt,
   input  wire logic           failTrigger,
   output logic                sdoOut,
   output logic                sdoOe,
   output srm_ctrl_bank_t      ctrlRegs,
   output logic [1:0]          modeRequest,
   output logic                modeRequestValid,
   output logic                supply2Enable,
   output logic                failOutputs,
   output srm_xcvr_t           xcvrState
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [1:0] csSync_q;
   logic [1:0] sclkSync_q;
   logic [1:0] sdiSync_q;
   logic [1:0] wakeSync_q;
   logic       csPrev_q;
   logic       sclkPrev_q;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         csSync_q   <= 2'h3;
         sclkSync_q <= 2'h0;
         sdiSync_q  <= 2'h0;
         wakeSync_q <= 2'h0;
         csPrev_q   <= 1'b1;
         sclkPrev_q <= 1'b0;
      end else begin
         csSync_q   <= {csSync_q[0], csPin_b};
         sclkSync_q <= {sclkSync_q[0], sclkPin};
         sdiSync_q  <= {sdiSync_q[0], sdiPin};
         wakeSync_q <= {wakeSync_q[0], wakePin};
         csPrev_q   <= csSync_q[1];
         sclkPrev_q <= sclkSync_q[1];
      end
   end

   logic csFall;
   logic csRise;
   logic sclkRise;
   logic sclkFall;
   logic selected;
   assign csFall   = csPrev_q && !csSync_q[1];
   assign csRise   = !csPrev_q && csSync_q[1];
   assign selected = !csSync_q[1];
   assign sclkRise = selected && !sclkPrev_q && sclkSync_q[1];
   assign sclkFall = selected && sclkPrev_q && !sclkSync_q[1];

   // ****************************************
   // register storage and decode
   // ****************************************
   localparam srm_ctrl_bank_t CtrlMask = `SRM_CTRL_MASKS;
   localparam srm_stat_bank_t StatMask = `SRM_STAT_MASKS;

   srm_ctrl_bank_t ctrlQ;
   srm_stat_bank_t statQ;
   logic [7:0]     wakeLvl_q;
   logic [15:0]    rx_q;
   logic [15:0]    tx_q;
   logic [4:0]     fallCnt_q;
   logic [4:0]     riseCnt_q;
   srm_mode_t      prevMode_q;
   srm_cmd_t       cmd;
   logic [7:0]     summary;
   logic [7:0]     readByte;
   logic [3:0]     ctrlIdx;
   logic [3:0]     statIdx;
   logic           ctrlHit;
   logic           statHit;
   logic           cmdStrobe;
   logic           cmdAccept;
   logic           modeChg;
   logic           inNormal;

   function automatic logic [3:0] ctrl_index(input logic [6:0] a);
      case (a)
         `SRM_ADDR_MODE_SUPPLY:  ctrl_index = 4'h0;
         `SRM_ADDR_HARDWARE:     ctrl_index = 4'h1;
         `SRM_ADDR_WATCHDOG:     ctrl_index = 4'h2;
         `SRM_ADDR_BUS_FIRST:    ctrl_index = 4'h3;
         `SRM_ADDR_BUS_SECOND:   ctrl_index = 4'h4;
         `SRM_ADDR_WAKE_FIRST:   ctrl_index = 4'h5;
         `SRM_ADDR_WAKE_SECOND:  ctrl_index = 4'h6;
         `SRM_ADDR_WAKE_PULL:    ctrl_index = 4'h7;
         `SRM_ADDR_CYCLIC_TIMER: ctrl_index = 4'h8;
         `SRM_ADDR_SCRATCH:      ctrl_index = 4'h9;
         default:                ctrl_index = 4'hF;
      endcase
   endfunction

   function automatic logic [3:0] stat_index(input logic [6:0] a);
      case (a)
         `SRM_ADDR_SUPPLY_STAT:  stat_index = 4'h0;
         `SRM_ADDR_THERMAL_STAT: stat_index = 4'h1;
         `SRM_ADDR_DEVICE_STAT:  stat_index = 4'h2;
         `SRM_ADDR_BUS_STAT_1:   stat_index = 4'h3;
         `SRM_ADDR_BUS_STAT_2:   stat_index = 4'h4;
         `SRM_ADDR_WAKE_STAT_1:  stat_index = 4'h5;
         `SRM_ADDR_WAKE_STAT_2:  stat_index = 4'h6;
         `SRM_ADDR_SWITCHER:     stat_index = 4'h7;
         `SRM_ADDR_WAKE_LEVEL:   stat_index = 4'h8;
         `SRM_ADDR_FAMILY_ID:    stat_index = 4'h9;
         default:                stat_index = 4'hF;
      endcase
   endfunction

   // byte order of the command word
   assign cmd      = rx_q;
   assign ctrlIdx  = ctrl_index(cmd.addr);
   assign statIdx  = stat_index(cmd.addr);
   assign ctrlHit  = (ctrlIdx < 4'hA);
   assign statHit  = (statIdx < 4'h8);
   assign inNormal = (actualMode == SRM_NORMAL);
   assign modeChg  = (actualMode != prevMode_q);

   // complete frames only, and not in the silent modes
   assign cmdStrobe = csRise && (fallCnt_q == `SRM_FRAME_BITS);
   assign cmdAccept = cmdStrobe && (actualMode != SRM_RESTART) && (actualMode != SRM_SLEEP) &&
                      (actualMode != SRM_FAILSAFE);

   // summary of status registers, wake level left out
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         summary[i] = |statQ[i];
      end
   end

   // read data from the address in the first byte
   logic [3:0] rdCtrl;
   logic [3:0] rdStat;
   assign rdCtrl = ctrl_index(rx_q[15:9]);
   assign rdStat = stat_index(rx_q[15:9]);

   always_comb begin
      readByte = 8'h00;
      if (rdCtrl < 4'hA) begin
         readByte = ctrlQ[rdCtrl];
      end else if (rdStat < 4'h8) begin
         readByte = statQ[rdStat[2:0]];
      end else if (rdStat == 4'h8) begin
         readByte = wakeLvl_q;
      end else if (rdStat == 4'h9) begin
         readByte = `SRM_FAMILY_ID; // arbitrary family and product value
      end
   end

   // ****************************************
   // serial shifter
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_q      <= 16'h0000;
         tx_q      <= 16'h0000;
         fallCnt_q <= 5'h00;
         riseCnt_q <= 5'h00;
         sdoOut    <= 1'b0;
         sdoOe     <= 1'b0;
      end else begin
         sdoOe <= selected;
         if (csFall) begin
            fallCnt_q <= 5'h00;
            riseCnt_q <= 5'h00;
            tx_q      <= {8'h00, summary};
            sdoOut    <= summary[0];
         end else if (sclkRise) begin
            riseCnt_q <= riseCnt_q + 5'h01;
            if (riseCnt_q == (`SRM_ADDR_BYTE_BITS - 5'h01)) begin
               tx_q[15:8] <= readByte;
               sdoOut     <= readByte[0];
            end else if (riseCnt_q < (`SRM_FRAME_BITS - 5'h01)) begin
               sdoOut <= tx_q[riseCnt_q[3:0] + 4'h1];
            end
         end else if (sclkFall) begin
            rx_q <= {sdiSync_q[1], rx_q[15:1]};
            if (fallCnt_q != 5'h1F) begin
               fallCnt_q <= fallCnt_q + 5'h01;
            end
         end
      end
   end

   // ****************************************
   // control registers and mode follow-up
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrlQ            <= '0;
         modeRequest      <= 2'h0;
         modeRequestValid <= 1'b0;
      end else begin
         modeRequestValid <= 1'b0;
         if (cmdAccept && ctrlHit && cmd.write) begin
            ctrlQ[ctrlIdx] <= cmd.data & CtrlMask[ctrlIdx];
            if (ctrlIdx == 4'h0) begin
               modeRequest      <= cmd.data[`SRM_MODE_MSB:`SRM_MODE_LSB];
               modeRequestValid <= 1'b1;
               if (!inNormal) begin
                  ctrlQ[0][`SRM_SUP2_MSB:`SRM_SUP2_LSB] <= ctrlQ[0][`SRM_SUP2_MSB:`SRM_SUP2_LSB];
               end
            end
         end
         if (modeChg) begin
            case (actualMode)
               SRM_SLEEP: begin
                  ctrlQ[0][`SRM_MODE_MSB:`SRM_MODE_LSB] <= `SRM_MODE_SLEEP;
                  if (ctrlQ[3][1:0] == `SRM_XCVR_ON) ctrlQ[3][1:0] <= `SRM_XCVR_WAKE;
                  if (ctrlQ[3][4:3] == `SRM_XCVR_ON) ctrlQ[3][4:3] <= `SRM_XCVR_WAKE;
                  if (ctrlQ[4][1:0] == `SRM_XCVR_ON) ctrlQ[4][1:0] <= `SRM_XCVR_WAKE;
                  if (ctrlQ[4][4:3] == `SRM_XCVR_ON) ctrlQ[4][4:3] <= `SRM_XCVR_WAKE;
                  if (ctrlQ[4][7:6] == `SRM_XCVR_ON) ctrlQ[4][7:6] <= `SRM_XCVR_WAKE;
               end
               SRM_STOP: ctrlQ[0][`SRM_MODE_MSB:`SRM_MODE_LSB] <= `SRM_MODE_STOP;
               default:  ctrlQ[0][`SRM_MODE_MSB:`SRM_MODE_LSB] <= `SRM_MODE_NORMAL;
            endcase
         end
      end
   end

   // ****************************************
   // mode tracking, supply two, transceivers
   // ****************************************
   srm_xcvr_t  xcvrCfg;
   logic [1:0] supply2Cfg;
   assign xcvrCfg = {ctrlQ[4][7:6], ctrlQ[4][4:3], ctrlQ[4][1:0], ctrlQ[3][4:3], ctrlQ[3][1:0]};
   assign supply2Cfg = ctrlQ[0][`SRM_SUP2_MSB:`SRM_SUP2_LSB];

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prevMode_q    <= SRM_INIT;
         supply2Enable <= 1'b0;
         xcvrState     <= '0;
         failOutputs   <= 1'b0;
      end else begin
         prevMode_q <= actualMode;
         case (actualMode)
            SRM_NORMAL: supply2Enable <= (supply2Cfg != `SRM_SUP2_OFF);
            SRM_STOP:   supply2Enable <= (supply2Cfg >= `SRM_SUP2_STOP_ON);
            SRM_SLEEP:  supply2Enable <= (supply2Cfg == `SRM_SUP2_SLEEP_ON);
            default:    supply2Enable <= 1'b0;
         endcase
         if (modeChg) begin
            for (int i = 0; i < 5; i++) begin
               xcvrState[i] <= (actualMode == SRM_SLEEP && xcvrCfg[i] == `SRM_XCVR_ON) ?
                               `SRM_XCVR_WAKE : xcvrCfg[i];
            end
         end
         // only reset releases the failure outputs
         failOutputs <= failOutputs | failTrigger | ctrlQ[1][`SRM_FO_ON_BIT];
      end
   end

   // ****************************************
   // status registers
   // ****************************************
   srm_stat_bank_t evt;
   always_comb begin
      evt = statusEvt;
      evt[2][`SRM_FO_STATE_BIT] = statusEvt[2][`SRM_FO_STATE_BIT] | failOutputs;
      if (!supply2Enable) begin
         evt[0][`SRM_SUP2_OT_BIT] = 1'b0;
         evt[0][`SRM_SUP2_UV_BIT] = 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gStat
         logic clrHit;
         assign clrHit = cmdAccept && statHit && cmd.write && (statIdx[2:0] == g);
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               statQ[g] <= 8'h00;
            end else begin
               // diagnosis of supply two keeps running while it is on
               statQ[g] <= ((clrHit ? 8'h00 : statQ[g]) | evt[g]) & StatMask[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wakeLvl_q <= 8'h00;
      end else begin
         wakeLvl_q <= {7'h00, wakeSync_q[1]};
      end
   end

   assign ctrlRegs = ctrlQ;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   chk_ctrl_write: assert property ((cmdAccept && cmd.write && ctrlIdx == 4'h1) |=>
      ctrlQ[1] == $past(cmd.data)) else $error("control write lost");
   chk_read_only: assert property ((cmdAccept && !cmd.write && !modeChg) |=>
      $stable(ctrlQ)) else $error("read changed control");
   chk_status_clr: assert property ((cmdAccept && cmd.write && statIdx == 4'h2 && evt[2] == 8'h00) |=>
      statQ[2] == 8'h00) else $error("status not cleared");
   chk_set_wins: assert property (statusEvt[1][0] |=> statQ[1][0])
      else $error("event lost during clear");
   chk_wake_level: assert property (wakeSync_q[1] |=> wakeLvl_q == 8'h01)
      else $error("wake level wrong");
   chk_summary_byte: assert property (csFall |=> tx_q[7:0] == $past(summary))
      else $error("summary byte wrong");
   chk_silent_mode: assert property ((cmdStrobe && actualMode == SRM_SLEEP && !modeChg) |=>
      $stable(ctrlQ)) else $error("command taken in sleep");
   chk_mode_update: assert property ((modeChg && actualMode == SRM_NORMAL) |=>
      ctrlQ[0][7:6] == 2'h0) else $error("mode bits stale");
   chk_sleep_bus: assert property ((modeChg && actualMode == SRM_SLEEP && ctrlQ[3][1:0] == 2'h3) |=>
      ctrlQ[3][1:0] == 2'h1) else $error("transceiver still on");
   chk_fail_hold: assert property ((failOutputs || failTrigger) |=> failOutputs)
      else $error("failure outputs dropped");
   chk_supply2_lock: assert property ((cmdAccept && ctrlIdx == 4'h0 && !inNormal && !modeChg) |=>
      $stable(ctrlQ[0][4:3])) else $error("supply two changed");
   chk_reserved_bits: assert property (ctrlQ[0][5] == 1'b0 && ctrlQ[6][7:1] == 7'h00)
      else $error("reserved bit set");

   cov_write: cover property (cmdAccept && cmd.write && ctrlHit);
   cov_clear: cover property (cmdAccept && cmd.write && statHit);
   cov_sleep: cover property (modeChg && actualMode == SRM_SLEEP);

endmodule // srm_register_map

// *** include/srm_map.svh ***
// register map, field positions, encodings and masks of the serial register map
`ifndef SRM_MAP_SVH
`define SRM_MAP_SVH

// ****************************************
// command word layout
// ****************************************
`define SRM_FRAME_BITS      5'h10
`define SRM_ADDR_BYTE_BITS  5'h08
`define SRM_CTRL_ADDR_MIN   7'h01
`define SRM_CTRL_ADDR_MAX   7'h1E
`define SRM_STAT_ADDR_MIN   7'h41
`define SRM_STAT_ADDR_MAX   7'h7E

// ****************************************
// control register addresses
// ****************************************
`define SRM_ADDR_MODE_SUPPLY  7'h01
`define SRM_ADDR_HARDWARE     7'h02
`define SRM_ADDR_WATCHDOG     7'h03
`define SRM_ADDR_BUS_FIRST    7'h04
`define SRM_ADDR_BUS_SECOND   7'h05
`define SRM_ADDR_WAKE_FIRST   7'h06
`define SRM_ADDR_WAKE_SECOND  7'h07
`define SRM_ADDR_WAKE_PULL    7'h08
`define SRM_ADDR_CYCLIC_TIMER 7'h0C
`define SRM_ADDR_SCRATCH      7'h1E

// ****************************************
// status register addresses
// ****************************************
`define SRM_ADDR_SUPPLY_STAT  7'h41
`define SRM_ADDR_THERMAL_STAT 7'h42
`define SRM_ADDR_DEVICE_STAT  7'h43
`define SRM_ADDR_BUS_STAT_1   7'h44
`define SRM_ADDR_BUS_STAT_2   7'h45
`define SRM_ADDR_WAKE_STAT_1  7'h46
`define SRM_ADDR_WAKE_STAT_2  7'h47
`define SRM_ADDR_WAKE_LEVEL   7'h48
`define SRM_ADDR_SWITCHER     7'h4C
`define SRM_ADDR_FAMILY_ID    7'h7E

// ****************************************
// writable bit masks, reserved bits clear
// ****************************************
`define SRM_CTRL_MASKS {8'hFF, 8'h07, 8'h03, 8'h01, 8'h44, 8'hFB, 8'hFB, 8'hFF, 8'hFF, 8'hDF}
`define SRM_STAT_MASKS {8'hF7, 8'h0F, 8'hB1, 8'h7E, 8'h67, 8'hFF, 8'h07, 8'hFD}

// ****************************************
// fields and encodings
// ****************************************
`define SRM_MODE_MSB        7
`define SRM_MODE_LSB        6
`define SRM_SUP2_MSB        4
`define SRM_SUP2_LSB        3
`define SRM_FO_ON_BIT       5
`define SRM_FO_STATE_BIT    0
`define SRM_SUP2_OT_BIT     4
`define SRM_SUP2_UV_BIT     3
`define SRM_MODE_NORMAL     2'h0
`define SRM_MODE_SLEEP      2'h1
`define SRM_MODE_STOP       2'h2
`define SRM_SUP2_OFF        2'h0
`define SRM_SUP2_STOP_ON    2'h2
`define SRM_SUP2_SLEEP_ON   2'h3
`define SRM_XCVR_ON         2'h3
`define SRM_XCVR_WAKE       2'h1
`define SRM_FAMILY_ID       8'h5A

`endif

// *** include/srm_pkg.sv ***
// types shared by the serial register map
package srm_pkg;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      SRM_NORMAL   = 3'b000,
      SRM_SLEEP    = 3'b001,
      SRM_STOP     = 3'b010,
      SRM_RESTART  = 3'b011,
      SRM_FAILSAFE = 3'b100,
      SRM_INIT     = 3'b101
   } srm_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic       write;
      logic [6:0] addr;
   } srm_cmd_t;

   typedef logic [9:0][7:0] srm_ctrl_bank_t;
   typedef logic [7:0][7:0] srm_stat_bank_t;
   typedef logic [4:0][1:0] srm_xcvr_t;

endpackage

// *** tb/srm_spi_master.sv ***
// serial master model driving 16-clock frames into the register map
module srm_spi_master (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        start,
   input  wire logic [15:0] txWord,
   input  wire logic        sdoOut,
   output logic             csPin_b,
   output logic             sclkPin,
   output logic             sdiPin,
   output logic             done,
   output logic [15:0]      rxWord
);
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // frame sequencer, 8 clk per serial clock
   // ****************************************
   localparam int NCLK = 16;
   logic busy;
   int   t;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         busy    <= 1'b0;
         t       <= 0;
         csPin_b <= 1'b1;
         sclkPin <= 1'b0;
         sdiPin  <= 1'b0;
         done    <= 1'b0;
         rxWord  <= 16'h0000;
      end else begin
         done <= 1'b0;
         if (!busy) begin
            sdiPin <= ~sdiPin;
            if (start) begin
               busy    <= 1'b1;
               t       <= 0;
               csPin_b <= 1'b0;
            end
         end else begin
            t <= t + 1;
            if (t >= 8 && t < 8 * NCLK + 8 && (t % 8) == 0) begin
               sclkPin <= 1'b1;
               sdiPin  <= txWord[(t - 8) / 8];
            end
            if (t >= 8 && t < 8 * NCLK + 8 && (t % 8) == 4) begin
               sclkPin <= 1'b0;
            end
            if ((t % 8) == 7 && t < 8 * NCLK) begin
               rxWord[(t - 7) / 8] <= sdoOut;
            end
            if (t == 8 * NCLK + 8) begin
               csPin_b <= 1'b1;
            end
            if (t == 8 * NCLK + 16) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule // srm_spi_master

// *** tb/srm_register_map_bench.sv ***
// self-checking bench of the serial register map
`include "srm_map.svh"
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin nFail++; \
   $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module srm_register_map_bench
   import srm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // signals and tables
   // ****************************************
   logic           clk_sys, rst_b, start, done, csPin_b, sclkPin, sdiPin, wakePin, failTrigger;
   logic           sdoOut, sdoOe, modeRequestValid, supply2Enable, failOutputs;
   logic [15:0]    txWord, rxWord;
   logic [1:0]     modeRequest;
   srm_mode_t      actualMode;
   srm_stat_bank_t statusEvt;
   srm_ctrl_bank_t ctrlRegs;
   srm_xcvr_t      xcvrState;
   int             nFail, totalChecks, nValid, cyc;
   localparam logic [6:0] ctrlAddr [10] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h0C, 7'h1E};
   localparam logic [7:0] ctrlMask [10] = '{8'hDF, 8'hFF, 8'hFF, 8'hFB, 8'hFB, 8'h44, 8'h01, 8'h03, 8'h07, 8'hFF};
   localparam logic [6:0] statAddr [8] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h4C};
   localparam logic [7:0] statMask [8] = '{8'hFD, 8'h07, 8'hFF, 8'h67, 8'h7E, 8'hB1, 8'h0F, 8'hF7};

   srm_register_map srm_register_map_inst (.clk_sys(clk_sys), .rst_b(rst_b), .csPin_b(csPin_b),
      .sclkPin(sclkPin), .sdiPin(sdiPin), .wakePin(wakePin), .actualMode(actualMode), .statusEvt(statusEvt),
      .failTrigger(failTrigger), .sdoOut(sdoOut), .sdoOe(sdoOe), .ctrlRegs(ctrlRegs), .modeRequest(modeRequest),
      .modeRequestValid(modeRequestValid), .supply2Enable(supply2Enable), .failOutputs(failOutputs),
      .xcvrState(xcvrState));
   srm_spi_master srm_spi_master_inst (.clk_sys(clk_sys), .rst_b(rst_b), .start(start), .txWord(txWord),
      .sdoOut(sdoOut), .csPin_b(csPin_b), .sclkPin(sclkPin), .sdiPin(sdiPin), .done(done), .rxWord(rxWord));

   // ****************************************
   // clock, watchdog, helpers
   // ****************************************
   initial clk_sys = 1'b0;
   always #10 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cyc++;
      if (modeRequestValid === 1'b1) nValid++;
      if (cyc == 30000) begin
         nFail++;
         $display("[ERR] %0t timeout", $time);
         conclude();
      end
   end

   function automatic logic [15:0] cmd(input logic [6:0] a, input logic w, input logic [7:0] d);
      return {d, w, a};
   endfunction

   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      int k;
      k = 0;
      @(posedge clk_sys);
      start  <= 1'b1;
      txWord <= w;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (8) @(posedge clk_sys);
      `CHK(sdoOe, 1'b1)
      while (done !== 1'b1 && k < 400) begin
         @(posedge clk_sys);
         k++;
      end
      if (k >= 400) begin
         nFail++;
         $display("[ERR] %0t frame stuck", $time);
      end
      r = rxWord;
      `CHK(sdoOe, 1'b0)
   endtask

   task automatic settle();
      repeat (5) @(posedge clk_sys);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_ctrl();
      logic [15:0] r;
      logic [7:0]  d;
      for (int i = 0; i < 10; i++) begin
         d = (i == 1) ? 8'hDF : 8'hFF;
         xfer(cmd(ctrlAddr[i], 1'b1, d), r);
         `CHK(r[15:8], 8'h00)
         xfer(cmd(ctrlAddr[i], 1'b0, 8'h00), r);
         `CHK(r[15:8], d & ctrlMask[i])
         `CHK(ctrlRegs[i], d & ctrlMask[i])
      end
      xfer(cmd(7'h1F, 1'b1, 8'h00), r);
      xfer(cmd(7'h1E, 1'b0, 8'h00), r);
      `CHK(r[15:8], 8'hFF)
      $display("t_ctrl done");
   endtask

   task automatic t_stat();
      logic [15:0] r;
      @(posedge clk_sys);
      statusEvt <= {8{8'hFF}};
      @(posedge clk_sys);
      statusEvt <= '0;
      settle();
      for (int i = 0; i < 8; i++) begin
         xfer(cmd(statAddr[i], 1'b0, 8'h00), r);
         `CHK(r[15:8], statMask[i])
         `CHK(r[7:0], 8'hFF)
      end
      for (int i = 0; i < 8; i++) begin
         xfer(cmd(statAddr[i], 1'b1, 8'h00), r);
         `CHK(r[15:8], statMask[i])
         xfer(cmd(statAddr[i], 1'b0, 8'h00), r);
         `CHK(r[15:8], 8'h00)
      end
      `CHK(r[7:0], 8'h00)
      $display("t_stat done");
   endtask

   task automatic t_wake();
      logic [15:0] r;
      wakePin <= 1'b1;
      settle();
      xfer(cmd(7'h48, 1'b0, 8'h00), r);
      `CHK(r[8], 1'b1)
      xfer(cmd(7'h48, 1'b1, 8'h00), r);
      xfer(cmd(7'h48, 1'b0, 8'h00), r);
      `CHK(r[8], 1'b1)
      `CHK(r[7:0], 8'h00)
      wakePin <= 1'b0;
      settle();
      xfer(cmd(7'h48, 1'b0, 8'h00), r);
      `CHK(r[8], 1'b0)
      xfer(cmd(7'h7E, 1'b1, 8'h00), r);
      `CHK(r[15:8], `SRM_FAMILY_ID)
      xfer(cmd(7'h7E, 1'b0, 8'h00), r);
      `CHK(r[15:8], `SRM_FAMILY_ID)
      $display("t_wake done");
   endtask

   task automatic t_mode();
      logic [15:0] r;
      int          n0;
      n0 = nValid;
      xfer(cmd(7'h01, 1'b1, 8'h58), r);
      `CHK(nValid - n0, 1)
      `CHK(modeRequest, 2'h1)
      `CHK(supply2Enable, 1'b1)
      @(posedge clk_sys);
      failTrigger <= 1'b1;
      @(posedge clk_sys);
      failTrigger <= 1'b0;
      actualMode <= SRM_SLEEP;
      settle();
      `CHK(xcvrState, {5{2'h1}})
      `CHK(ctrlRegs[3][1:0], 2'h1)
      `CHK(ctrlRegs[0][7:6], 2'h1)
      `CHK(failOutputs, 1'b1)
      `CHK(supply2Enable, 1'b1)
      n0 = nValid;
      xfer(cmd(7'h1E, 1'b1, 8'h00), r);
      `CHK(ctrlRegs[9], 8'hFF)
      actualMode <= SRM_RESTART;
      settle();
      xfer(cmd(7'h01, 1'b1, 8'h00), r);
      actualMode <= SRM_FAILSAFE;
      settle();
      `CHK(supply2Enable, 1'b0)
      xfer(cmd(7'h1E, 1'b1, 8'h00), r);
      `CHK(ctrlRegs[9], 8'hFF)
      `CHK(nValid - n0, 0)
      actualMode <= SRM_STOP;
      settle();
      xfer(cmd(7'h01, 1'b1, 8'h80), r);
      `CHK(r[15:8], 8'h98)
      xfer(cmd(7'h01, 1'b0, 8'h00), r);
      `CHK(r[15:8], 8'h98)
      `CHK(supply2Enable, 1'b1)
      @(posedge clk_sys);
      statusEvt[0] <= 8'h18;
      @(posedge clk_sys);
      statusEvt[0] <= 8'h00;
      settle();
      xfer(cmd(7'h41, 1'b0, 8'h00), r);
      `CHK(r[12:11], 2'h3)
      actualMode <= SRM_NORMAL;
      settle();
      xfer(cmd(7'h01, 1'b0, 8'h00), r);
      `CHK(r[15:14], 2'h0)
      $display("t_mode done");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_b       = 1'b0;
      start       = 1'b0;
      txWord      = 16'h0000;
      wakePin     = 1'b0;
      failTrigger = 1'b0;
      actualMode  = SRM_NORMAL;
      statusEvt   = '0;
      nFail       = 0;
      totalChecks = 0;
      nValid      = 0;
      cyc         = 0;
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_ctrl();
      t_stat();
      t_wake();
      t_mode();
      conclude();
   end
endmodule // srm_register_map_bench
